// >>> logic/timer_counter_pkg.sv
// timer_counter_pkg: register map, field layout, encodings and carrier types
// assumes: a 32-bit APB slave, one register per aligned word
package timer_counter_pkg;

	// ==========================================================
	// register byte addresses
	localparam logic [7:0] SC_OFF     = 8'h00;
	localparam logic [7:0] CNTH_OFF   = 8'h04;
	localparam logic [7:0] CNTL_OFF   = 8'h08;
	localparam logic [7:0] MODH_OFF   = 8'h0c;
	localparam logic [7:0] MODL_OFF   = 8'h10;
	localparam logic [7:0] CHMODE_OFF = 8'h14;

	// ==========================================================
	// status-control field positions
	localparam int SC_OVF_BIT  = 7;
	localparam int SC_IE_BIT   = 6;
	localparam int SC_CPWM_BIT = 5;
	localparam int SC_CLKS_HI  = 4;
	localparam int SC_CLKS_LO  = 3;
	localparam int SC_PS_HI    = 2;
	localparam int SC_PS_LO    = 0;

	// ==========================================================
	// sizes and constants
	localparam int          NUM_CH    = 4;
	localparam int          CNT_W     = 16;
	localparam int          PRE_W     = 7;
	localparam logic [15:0] CNT_ZERO  = 16'h0000;
	localparam logic [15:0] CNT_ONE   = 16'h0001;
	localparam logic [15:0] CNT_FULL  = 16'hffff;
	localparam logic [15:0] MOD_RESET = 16'h0000;
	localparam logic [7:0]  BYTE_ZERO = 8'h00;
	localparam logic [PRE_W-1:0] DIV_ZERO = 7'h00;
	localparam logic [PRE_W-1:0] DIV_ONE  = 7'h01;

	// clock source field encodings
	localparam logic [1:0] CLKS_OFF   = 2'h0;
	localparam logic [1:0] CLKS_BUS   = 2'h1;
	localparam logic [1:0] CLKS_FIXED = 2'h2;
	localparam logic [1:0] CLKS_EXT   = 2'h3;

	// ==========================================================
	// types
	typedef enum logic [3:0] {
		CHM_CAPTURE    = 4'h1,
		CHM_COMPARE    = 4'h2,
		CHM_EDGE_PWM   = 4'h4,
		CHM_CENTER_PWM = 4'h8
	} ch_mode_t;

	typedef enum logic [1:0] {
		RD_LIVE = 2'h1,
		RD_HELD = 2'h2
	} rd_state_t;

	typedef struct packed {
		logic [1:0] clks;
		logic [2:0] ps;
		logic       pll_ok;
	} tick_cfg_t;

	typedef struct packed {
		logic rd_hi;
		logic rd_lo;
		logic restart;
		logic freeze;
	} rd_ctl_t;

endpackage

// >>> logic/timer_tick_gen.sv
// timer_tick_gen: clock source synchronisers, source select, prescaler
// assumes: ext and fixed clock inputs are slow against CLK
`timescale 1ns/1ps
module timer_tick_gen (
	// clock and reset
	input  wire logic                         clk,
	input  wire logic                         rst,
	// configuration
	input  wire timer_counter_pkg::tick_cfg_t cfg,
	input  wire logic                         halt,
	// raw sources
	input  wire logic                         ext_clk,
	input  wire logic                         fixed_clk,
	// counting tick
	output logic                              tick
);

	// prescaler width, needed by the mask cast below
	localparam int PRE_W = timer_counter_pkg::PRE_W;

	typedef struct packed {
		logic [2:0]                          ext_s;
		logic [2:0]                          fix_s;
		logic [timer_counter_pkg::PRE_W-1:0] div;
	} tick_state_t;

	tick_state_t                         s_r;
	tick_state_t                         s_nxt;
	logic                                src_pulse;
	logic [timer_counter_pkg::PRE_W-1:0] mask;

	// ==========================================================
	// next state and tick
	always_comb begin
		s_nxt = s_r;
		// [R4] two-stage synchronisers, third stage for edges
		s_nxt.ext_s = {s_r.ext_s[1:0], ext_clk};
		s_nxt.fix_s = {s_r.fix_s[1:0], fixed_clk};
		// [R3] source select by field
		case (cfg.clks)
			timer_counter_pkg::CLKS_OFF:   src_pulse = 1'b0;
			timer_counter_pkg::CLKS_BUS:   src_pulse = 1'b1;
			// [R5] fixed clock falls back to bus rate
			timer_counter_pkg::CLKS_FIXED: src_pulse = cfg.pll_ok ?
				(s_r.fix_s[1] & ~s_r.fix_s[2]) : 1'b1;
			timer_counter_pkg::CLKS_EXT:
				src_pulse = s_r.ext_s[1] & ~s_r.ext_s[2];
			default:                       src_pulse = 1'b0;
		endcase
		// [R6] divide by two to the field value
		mask = PRE_W'((8'h01 << cfg.ps) - 8'h01);
		// [R7] prescaler counts the selected source
		if (cfg.clks == timer_counter_pkg::CLKS_OFF) begin
			s_nxt.div = timer_counter_pkg::DIV_ZERO;
		end else if (src_pulse && !halt) begin
			s_nxt.div = s_r.div + timer_counter_pkg::DIV_ONE;
		end
		// [R8] new factor used on the following cycle
		tick = src_pulse && !halt && ((s_r.div & mask) == mask);
		if (rst) begin
			s_nxt = '0;
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk) begin
		s_r <= s_nxt;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_no_clock_tick: assert property ( // [R3]
		cfg.clks == timer_counter_pkg::CLKS_OFF |-> !tick)
		else $error("tick with no clock source");
	chk_bus_div_one: assert property ( // [R6]
		cfg.clks == timer_counter_pkg::CLKS_BUS && cfg.ps == 3'h0
		&& !halt |-> tick)
		else $error("bus clock divide by one missed a tick");

endmodule // timer_tick_gen

// >>> logic/count_read_latch.sv
// count_read_latch: two-byte coherent read buffer for the counter
// assumes: at most one byte read per cycle
`timescale 1ns/1ps
module count_read_latch (
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst,
	// live counter and controls
	input  wire logic [15:0]                cnt,
	input  wire timer_counter_pkg::rd_ctl_t ctl,
	// read bytes
	output logic [7:0]                      hi_byte,
	output logic [7:0]                      lo_byte
);

	typedef struct packed {
		timer_counter_pkg::rd_state_t st;
		logic [15:0]                  buf_val;
		logic                         owe_hi;
	} latch_state_t;

	latch_state_t s_r;
	latch_state_t s_nxt;

	// ==========================================================
	// next state
	always_comb begin
		s_nxt = s_r;
		if (ctl.restart) begin
			// [R10] restart drops any held value
			s_nxt.st = timer_counter_pkg::RD_LIVE;
		end else if (!ctl.freeze) begin
			case (s_r.st)
				timer_counter_pkg::RD_LIVE: begin
					// [R9] first byte read captures both
					if (ctl.rd_hi || ctl.rd_lo) begin
						s_nxt.st      = timer_counter_pkg::RD_HELD;
						s_nxt.buf_val = cnt;
						s_nxt.owe_hi  = ctl.rd_lo;
					end
				end
				timer_counter_pkg::RD_HELD: begin
					if ((ctl.rd_hi && s_r.owe_hi) ||
						(ctl.rd_lo && !s_r.owe_hi)) begin
						s_nxt.st = timer_counter_pkg::RD_LIVE;
					end
				end
				default: s_nxt.st = timer_counter_pkg::RD_LIVE;
			endcase
		end
		if (rst) begin
			s_nxt.st      = timer_counter_pkg::RD_LIVE;
			s_nxt.buf_val = timer_counter_pkg::CNT_ZERO;
			s_nxt.owe_hi  = 1'b0;
		end
	end

	// held value while latched, live value otherwise
	assign hi_byte = (s_r.st == timer_counter_pkg::RD_HELD) ?
		s_r.buf_val[15:8] : cnt[15:8];
	assign lo_byte = (s_r.st == timer_counter_pkg::RD_HELD) ?
		s_r.buf_val[7:0] : cnt[7:0];

	// ==========================================================
	// state register
	always_ff @(posedge clk) begin
		s_r <= s_nxt;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_restart_live: assert property ( // [R10]
		ctl.restart |=> s_r.st == timer_counter_pkg::RD_LIVE)
		else $error("restart did not release the read buffer");
	chk_freeze_hold: assert property ( // [R13]
		ctl.freeze && !ctl.restart |=> $stable(s_r))
		else $error("read buffer moved while frozen");
	chk_capture_value: assert property ( // [R9]
		s_r.st == timer_counter_pkg::RD_LIVE && ctl.rd_hi && !ctl.freeze
		&& !ctl.restart |=> s_r.buf_val == $past(cnt)
		&& hi_byte == $past(cnt[15:8]))
		else $error("read buffer did not capture the counter");

endmodule // count_read_latch

// >>> logic/timer_counter_core.sv
// timer_counter_core: 16-bit timer counter core with APB registers
// assumes: APB master on CLK; channel logic uses COUNT, COUNT_DOWN, CH_MODE
//
// Operation
// [R1] up only unless center-aligned, else up/down
// [R2] center select forces center PWM on channels
// [R3] clock source field: off, bus, fixed, external
// [R4] external and fixed clocks synchronised first
// [R5] fixed clock equals bus clock without PLL
// [R6] prescale divides by two to the field
// [R7] prescaler follows source sync and select
// [R8] new prescale acts on the next cycle
// [R9] byte read latches both bytes until other
// [R10] reset or control write restarts read buffer
// [R11] counter byte write clears counter, restarts buffer
// [R12] reset clears counter
// [R13] halt freezes counter and read buffer
// [R14] writes still restart read buffer during halt
// [R15] counter at modulo wraps to zero, flags
// [R16] half-written modulo inhibits overflow flag
// [R17] modulo resets to zero, free running
// [R18] no clock: modulo loads on second byte
// [R19] clocked: modulo loads stepping into limit
// [R20] control write resets modulo write sequence
// [R21] halt freezes sequence, modulo writes go direct
// [R22] software clears counter before new modulo
// [R23] flag clears by read then zero write
// [R24] interrupt when flag and enable set
// [R25] counter steps per tick, holds without clock
`timescale 1ns/1ps
module timer_counter_core (
	// clock and reset
	input  wire logic                                 CLK,
	input  wire logic                                 RST,
	// apb slave
	input  wire logic                                 PSEL,
	input  wire logic                                 PENABLE,
	input  wire logic                                 PWRITE,
	input  wire logic [7:0]                           PADDR,
	input  wire logic [31:0]                          PWDATA,
	output logic      [31:0]                          PRDATA,
	output logic                                      PREADY,
	output logic                                      PSLVERR,
	// clock sources and system state
	input  wire logic                                 EXT_CLK_IN,
	input  wire logic                                 FIXED_CLK_IN,
	input  wire logic                                 PLL_PRESENT,
	input  wire logic                                 PLL_ENABLED,
	input  wire logic                                 DEBUG_HALT,
	// to channel logic, and overflow interrupt
	output logic      [15:0]                          COUNT,
	output logic                                      COUNT_DOWN,
	output timer_counter_pkg::ch_mode_t [3:0]         CH_MODE,
	output logic                                      OVF_IRQ
);

	localparam int NCH = timer_counter_pkg::NUM_CH;

	typedef struct packed {
		logic                                 ovf;
		logic                                 ovf_ie;
		logic                                 cpwm;
		logic [1:0]                           clks;
		logic [2:0]                           ps;
		logic                                 ovf_armed;
		logic [15:0]                          cnt;
		logic                                 down;
		logic [15:0]                          mod;
		logic [15:0]                          mod_buf;
		logic                                 mod_hi_seen;
		logic                                 mod_lo_seen;
		logic [2*NCH-1:0]                     ch_cfg;
		timer_counter_pkg::ch_mode_t [NCH-1:0] ch_mode;
		logic                                 pready;
		logic                                 pslverr;
		logic [31:0]                          prdata;
		logic                                 irq;
	} core_state_t;

	core_state_t                            s_r;
	core_state_t                            s_nxt;
	timer_counter_pkg::tick_cfg_t           tcfg;
	timer_counter_pkg::rd_ctl_t             rctl;
	timer_counter_pkg::ch_mode_t [NCH-1:0]  ch_mode_w;
	logic                                   tick;
	logic [7:0]                             cnt_hi_rd;
	logic [7:0]                             cnt_lo_rd;
	logic                                   rd_evt;
	logic                                   wr_evt;
	logic [7:0]                             wd;
	logic                                   sc_wr;
	logic                                   cnt_wr;
	logic                                   modh_wr;
	logic                                   modl_wr;
	logic [15:0]                            limit;
	logic                                   ovf_evt;
	logic                                   into_limit;
	logic                                   mapped;

	// ==========================================================
	// bus decode
	assign rd_evt  = PSEL && PENABLE && !s_r.pready && !PWRITE;
	assign wr_evt  = PSEL && PENABLE && s_r.pready && PWRITE;
	assign wd      = PWDATA[7:0];
	assign sc_wr   = wr_evt && (PADDR == timer_counter_pkg::SC_OFF);
	assign cnt_wr  = wr_evt && (PADDR == timer_counter_pkg::CNTH_OFF ||
		PADDR == timer_counter_pkg::CNTL_OFF);
	assign modh_wr = wr_evt && (PADDR == timer_counter_pkg::MODH_OFF);
	assign modl_wr = wr_evt && (PADDR == timer_counter_pkg::MODL_OFF);
	assign mapped  = PADDR == timer_counter_pkg::SC_OFF ||
		PADDR == timer_counter_pkg::CNTH_OFF ||
		PADDR == timer_counter_pkg::CNTL_OFF ||
		PADDR == timer_counter_pkg::MODH_OFF ||
		PADDR == timer_counter_pkg::MODL_OFF ||
		PADDR == timer_counter_pkg::CHMODE_OFF;

	// ==========================================================
	// tick generator
	assign tcfg.clks   = s_r.clks;
	assign tcfg.ps     = s_r.ps;
	assign tcfg.pll_ok = PLL_PRESENT && PLL_ENABLED;

	timer_tick_gen u_tick (
		.clk       (CLK),
		.rst       (RST),
		.cfg       (tcfg),
		.halt      (DEBUG_HALT),
		.ext_clk   (EXT_CLK_IN),
		.fixed_clk (FIXED_CLK_IN),
		.tick      (tick)
	);

	// ==========================================================
	// coherent counter reads
	assign rctl.rd_hi   = rd_evt && (PADDR == timer_counter_pkg::CNTH_OFF);
	assign rctl.rd_lo   = rd_evt && (PADDR == timer_counter_pkg::CNTL_OFF);
	// [R14] restart on control or counter write, even in halt
	assign rctl.restart = sc_wr || cnt_wr;
	// [R13] halt freezes the read buffer
	assign rctl.freeze  = DEBUG_HALT;

	count_read_latch u_rdlatch (
		.clk     (CLK),
		.rst     (RST),
		.cnt     (s_r.cnt),
		.ctl     (rctl),
		.hi_byte (cnt_hi_rd),
		.lo_byte (cnt_lo_rd)
	);

	// ==========================================================
	// per-channel effective mode
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_ch
			// [R2] center select overrides channel mode bits
			assign ch_mode_w[gi] = s_r.cpwm ?
				timer_counter_pkg::CHM_CENTER_PWM :
				s_r.ch_cfg[2*gi+1] ? timer_counter_pkg::CHM_EDGE_PWM :
				s_r.ch_cfg[2*gi]   ? timer_counter_pkg::CHM_COMPARE :
				timer_counter_pkg::CHM_CAPTURE;
		end
	endgenerate

	// [R17] zero modulo counts the full range
	assign limit = (s_r.mod == timer_counter_pkg::MOD_RESET) ?
		timer_counter_pkg::CNT_FULL : s_r.mod;

	// ==========================================================
	// next state
	always_comb begin
		s_nxt      = s_r;
		ovf_evt    = 1'b0;
		into_limit = 1'b0;
		s_nxt.ch_mode = ch_mode_w;

		// [R11] counter byte write clears the whole counter
		if (cnt_wr) begin
			s_nxt.cnt  = timer_counter_pkg::CNT_ZERO;
			s_nxt.down = 1'b0;
		end else if (tick) begin
			// [R25] one step per prescaled tick
			if (!s_r.cpwm) begin
				// [R1] up counting only
				s_nxt.down = 1'b0;
				into_limit = s_r.cnt == limit - timer_counter_pkg::CNT_ONE;
				// [R15] wrap to zero after the limit
				if (s_r.cnt == limit) begin
					s_nxt.cnt = timer_counter_pkg::CNT_ZERO;
					ovf_evt   = 1'b1;
				end else begin
					s_nxt.cnt = s_r.cnt + timer_counter_pkg::CNT_ONE;
				end
			end else if (!s_r.down) begin
				// [R1] up leg of up/down counting
				into_limit = s_r.cnt == limit - timer_counter_pkg::CNT_ONE;
				if (s_r.cnt >= limit) begin
					s_nxt.down = 1'b1;
					s_nxt.cnt  = s_r.cnt - timer_counter_pkg::CNT_ONE;
					ovf_evt    = 1'b1;
				end else begin
					s_nxt.cnt = s_r.cnt + timer_counter_pkg::CNT_ONE;
				end
			end else begin
				if (s_r.cnt == timer_counter_pkg::CNT_ZERO) begin
					s_nxt.down = 1'b0;
					s_nxt.cnt  = timer_counter_pkg::CNT_ONE;
				end else begin
					s_nxt.cnt = s_r.cnt - timer_counter_pkg::CNT_ONE;
				end
			end
		end

		// [R19] buffered modulo loads when stepping into the limit
		if (into_limit && s_r.mod_hi_seen && s_r.mod_lo_seen &&
			!DEBUG_HALT) begin
			s_nxt.mod         = s_r.mod_buf;
			s_nxt.mod_hi_seen = 1'b0;
			s_nxt.mod_lo_seen = 1'b0;
		end

		// modulo byte writes
		if (DEBUG_HALT) begin
			// [R21] direct writes, sequence frozen
			if (modh_wr) s_nxt.mod[15:8] = wd;
			if (modl_wr) s_nxt.mod[7:0]  = wd;
		end else if (modh_wr || modl_wr) begin
			if (modh_wr) begin
				s_nxt.mod_buf[15:8] = wd;
				s_nxt.mod_hi_seen   = 1'b1;
			end else begin
				s_nxt.mod_buf[7:0]  = wd;
				s_nxt.mod_lo_seen   = 1'b1;
			end
			// [R18] no clock: load as soon as both bytes are in
			if (s_r.clks == timer_counter_pkg::CLKS_OFF &&
				s_nxt.mod_hi_seen && s_nxt.mod_lo_seen) begin
				s_nxt.mod         = s_nxt.mod_buf;
				s_nxt.mod_hi_seen = 1'b0;
				s_nxt.mod_lo_seen = 1'b0;
			end
		end

		// [R23] flag read while set arms the clear
		if (rd_evt && PADDR == timer_counter_pkg::SC_OFF && s_r.ovf) begin
			s_nxt.ovf_armed = 1'b1;
		end

		// control register write
		if (sc_wr) begin
			s_nxt.ovf_ie = wd[timer_counter_pkg::SC_IE_BIT];
			s_nxt.cpwm   = wd[timer_counter_pkg::SC_CPWM_BIT];
			// [R1] leaving center mode drops the down leg
			if (!wd[timer_counter_pkg::SC_CPWM_BIT]) begin
				s_nxt.down = 1'b0;
			end
			s_nxt.clks   = wd[timer_counter_pkg::SC_CLKS_HI:
				timer_counter_pkg::SC_CLKS_LO];
			s_nxt.ps     = wd[timer_counter_pkg::SC_PS_HI:
				timer_counter_pkg::SC_PS_LO];
			// [R23] zero write clears only when armed
			if (!wd[timer_counter_pkg::SC_OVF_BIT] && s_r.ovf_armed) begin
				s_nxt.ovf = 1'b0;
			end
			s_nxt.ovf_armed   = 1'b0;
			// [R20] control write restarts the modulo sequence
			s_nxt.mod_hi_seen = 1'b0;
			s_nxt.mod_lo_seen = 1'b0;
		end
		if (wr_evt && PADDR == timer_counter_pkg::CHMODE_OFF) begin
			s_nxt.ch_cfg = wd;
		end

		// [R16] no flag while only one modulo byte is in
		if (ovf_evt && !(s_r.mod_hi_seen ^ s_r.mod_lo_seen)) begin
			// [R23] new overflow wins and restarts the clear sequence
			s_nxt.ovf       = 1'b1;
			s_nxt.ovf_armed = 1'b0;
		end

		// [R24] interrupt request follows flag and enable
		s_nxt.irq = s_nxt.ovf && s_nxt.ovf_ie;

		// bus answer one cycle into the access phase
		s_nxt.pready  = PSEL && PENABLE && !s_r.pready;
		s_nxt.pslverr = s_nxt.pready && !mapped;
		s_nxt.prdata  = '0;
		if (rd_evt) begin
			case (PADDR)
				timer_counter_pkg::SC_OFF:     s_nxt.prdata[7:0] = {s_r.ovf,
					s_r.ovf_ie, s_r.cpwm, s_r.clks, s_r.ps};
				timer_counter_pkg::CNTH_OFF:   s_nxt.prdata[7:0] = cnt_hi_rd;
				timer_counter_pkg::CNTL_OFF:   s_nxt.prdata[7:0] = cnt_lo_rd;
				timer_counter_pkg::MODH_OFF:   s_nxt.prdata[7:0] = s_r.mod[15:8];
				timer_counter_pkg::MODL_OFF:   s_nxt.prdata[7:0] = s_r.mod[7:0];
				timer_counter_pkg::CHMODE_OFF: s_nxt.prdata[7:0] = s_r.ch_cfg;
				default:                       s_nxt.prdata[7:0] =
					timer_counter_pkg::BYTE_ZERO;
			endcase
		end

		// [R12] reset clears counter, modulo and controls
		if (RST) begin
			s_nxt         = '0;
			s_nxt.ch_mode = {NCH{timer_counter_pkg::CHM_CAPTURE}};
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge CLK) begin
		s_r <= s_nxt;
	end

	// outputs straight from the state register
	assign PRDATA     = s_r.prdata;
	assign PREADY     = s_r.pready;
	assign PSLVERR    = s_r.pslverr;
	assign COUNT      = s_r.cnt;
	assign COUNT_DOWN = s_r.down;
	assign CH_MODE    = s_r.ch_mode;
	assign OVF_IRQ    = s_r.irq;

	// ==========================================================
	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	chk_up_only_mode: assert property ( // [R1]
		!s_r.cpwm |=> !s_r.down)
		else $error("counter moved down outside center mode");
	chk_center_channels: assert property ( // [R2]
		s_r.cpwm ##1 s_r.cpwm |-> CH_MODE[0] ==
		timer_counter_pkg::CHM_CENTER_PWM)
		else $error("channel not in center mode");
	chk_count_write_clear: assert property ( // [R11]
		cnt_wr |=> COUNT == timer_counter_pkg::CNT_ZERO)
		else $error("counter write did not clear counter");
	chk_wrap_to_zero: assert property ( // [R15]
		tick && !s_r.cpwm && !cnt_wr && s_r.cnt == limit
		&& !(s_r.mod_hi_seen ^ s_r.mod_lo_seen)
		|=> COUNT == timer_counter_pkg::CNT_ZERO && s_r.ovf)
		else $error("counter did not wrap with flag");
	chk_halt_count_hold: assert property ( // [R13]
		DEBUG_HALT && !cnt_wr |=> $stable(COUNT))
		else $error("counter moved during halt");
	chk_no_clock_hold: assert property ( // [R25]
		s_r.clks == timer_counter_pkg::CLKS_OFF && !cnt_wr
		|=> $stable(COUNT))
		else $error("counter moved with no clock");
	chk_flag_inhibit: assert property ( // [R16]
		(s_r.mod_hi_seen ^ s_r.mod_lo_seen) && !s_r.ovf |=> !s_r.ovf)
		else $error("flag set during half modulo write");
	chk_flag_clear_seq: assert property ( // [R23]
		$fell(s_r.ovf) |-> $past(sc_wr && s_r.ovf_armed
		&& !wd[timer_counter_pkg::SC_OVF_BIT]))
		else $error("flag cleared without read then zero write");
	chk_irq_follows: assert property ( // [R24]
		s_r.ovf && s_r.ovf_ie |-> OVF_IRQ)
		else $error("interrupt missing with flag and enable");
	chk_modulo_direct: assert property ( // [R21]
		DEBUG_HALT && modl_wr |=> s_r.mod[7:0] == $past(wd)
		&& $stable(s_r.mod_lo_seen))
		else $error("halt modulo write not direct");
	chk_answer_time: assert property (
		PSEL && PENABLE && !PREADY |=> PREADY)
		else $error("bus answer late");

endmodule // timer_counter_core

// >>> sim/timer_counter_core_tb.sv
// timer_counter_core_tb: self-checking bench for the timer counter core
// assumes: one-wait-state APB slave, CLK at 100 MHz
`timescale 1ns/1ps
module timer_counter_core_tb;
	// ==========================================================
	// stimulus and observed signals
	logic        CLK = 1'b0;
	logic        RST = 1'b1;
	logic        PSEL = 1'b0;
	logic        PENABLE = 1'b0;
	logic        PWRITE = 1'b0;
	logic [7:0]  PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0;
	logic        EXT_CLK_IN = 1'b0;
	logic        FIXED_CLK_IN = 1'b0;
	logic        PLL_PRESENT = 1'b0;
	logic        PLL_ENABLED = 1'b0;
	logic        DEBUG_HALT = 1'b0;
	logic [31:0] PRDATA, rd;
	logic        PREADY, PSLVERR, COUNT_DOWN, OVF_IRQ, dn, err;
	logic [15:0] COUNT, top, e;
	logic [7:0]  rnd = 8'h37, m, cfg[7];
	int          fail_count = 0, comparisons = 0, cyc = 0;
	timer_counter_pkg::ch_mode_t [3:0] CH_MODE;

	always #5 CLK = ~CLK;

	timer_counter_core i_dut (.CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR,
		.PWDATA, .PRDATA, .PREADY, .PSLVERR, .EXT_CLK_IN, .FIXED_CLK_IN,
		.PLL_PRESENT, .PLL_ENABLED, .DEBUG_HALT, .COUNT, .COUNT_DOWN,
		.CH_MODE, .OVF_IRQ);

	// ==========================================================
	// slow sources (external edge every 8 cycles) and timeout
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		EXT_CLK_IN <= cyc[2];
		FIXED_CLK_IN <= cyc[0];
		if (cyc == 20000) begin
			fail_count++;
			end_of_test();
		end
	end

	// ==========================================================
	// helpers
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %s %h not %h", $time, what, seen, exp);
		end
	endtask

	// one transfer: setup, access held until pready sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= {24'h0, d};
		@(posedge CLK);
		PENABLE <= 1'b1;
		@(posedge CLK);
		while (PREADY !== 1'b1) @(posedge CLK);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	// track highest count and any down leg over n cycles
	task automatic watch(input int n);
		top = 16'h0000;
		dn = 1'b0;
		repeat (n) begin
			@(posedge CLK);
			if (COUNT > top) top = COUNT;
			dn |= COUNT_DOWN;
		end
	endtask

	task end_of_test();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		repeat (2) @(posedge CLK);
		RST <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, 8'(i * 4), 8'h00);
			check(rd, 32'h0, "reset");
		end
		check(CH_MODE, {4{timer_counter_pkg::CHM_CAPTURE}}, "mode");
		apb(1'b0, 8'h20, 8'h00);
		check(err, 1'b1, "unmapped");
		// random limits: load, wrap, flag, interrupt, clearing
		for (int k = 0; k < 3; k++) begin
			rnd = lfsr(rnd);
			m = 8'h04 + {4'h0, rnd[3:0]};
			apb(1'b0, timer_counter_pkg::SC_OFF, 8'h00);
			apb(1'b1, timer_counter_pkg::SC_OFF, 8'h00);
			// counter cleared before a new limit
			apb(1'b1, timer_counter_pkg::CNTL_OFF, 8'h5a);
			apb(1'b1, timer_counter_pkg::MODH_OFF, 8'h00);
			apb(1'b1, timer_counter_pkg::MODL_OFF, m);
			@(posedge CLK);
			check(COUNT, 16'h0000, "clear");
			apb(1'b1, timer_counter_pkg::SC_OFF, 8'h48);
			watch(40);
			check(top, {8'h00, m}, "limit");
			check(dn, 1'b0, "up only");
			apb(1'b0, timer_counter_pkg::SC_OFF, 8'h00);
			check(rd[7], 1'b1, "flag");
			check(OVF_IRQ, 1'b1, "irq");
			apb(1'b1, timer_counter_pkg::SC_OFF, 8'h80);
			apb(1'b0, timer_counter_pkg::SC_OFF, 8'h00);
			check(rd[7], 1'b1, "one");
			apb(1'b1, timer_counter_pkg::SC_OFF, 8'h00);
			apb(1'b0, timer_counter_pkg::SC_OFF, 8'h00);
			check(rd[7], 1'b0, "zero");
		end
		// one limit byte holds the flag off until the other
		apb(1'b1, timer_counter_pkg::SC_OFF, 8'h08);
		apb(1'b1, timer_counter_pkg::MODL_OFF, m);
		watch(40);
		apb(1'b0, timer_counter_pkg::SC_OFF, 8'h00);
		check(rd[7], 1'b0, "inhibit");
		apb(1'b1, timer_counter_pkg::MODH_OFF, 8'h00);
		watch(40);
		apb(1'b0, timer_counter_pkg::SC_OFF, 8'h00);
		check(rd[7], 1'b1, "release");
		// center-aligned counting
		apb(1'b1, timer_counter_pkg::SC_OFF, 8'h28);
		watch(60);
		check(dn, 1'b1, "down");
		check(top, {8'h00, m}, "turn");
		check(CH_MODE, {4{timer_counter_pkg::CHM_CENTER_PWM}}, "cpwm");
		// free running: sources and prescale, frozen by halt
		apb(1'b1, timer_counter_pkg::SC_OFF, 8'h00);
		apb(1'b1, timer_counter_pkg::MODH_OFF, 8'h00);
		apb(1'b1, timer_counter_pkg::MODL_OFF, 8'h00);
		rnd = lfsr(rnd);
		cfg = '{8'h08, 8'h10, 8'h0b, 8'h0f, 8'h18, {5'h01, rnd[2:0]}, 8'h10};
		foreach (cfg[j]) begin
			// last entry: fixed clock with a running PLL
			PLL_PRESENT <= (j == 6);
			PLL_ENABLED <= (j == 6);
			apb(1'b1, timer_counter_pkg::SC_OFF, 8'h00);
			apb(1'b1, timer_counter_pkg::CNTH_OFF, 8'h00);
			apb(1'b1, timer_counter_pkg::SC_OFF, cfg[j]);
			repeat (256) @(posedge CLK);
			DEBUG_HALT <= 1'b1;
			e = (cfg[j][4:3] == 2'h3) ? 16'h0020 :
				(j == 6) ? 16'h0080 : 16'h0100 >> cfg[j][2:0];
			repeat (2) @(posedge CLK);
			top = COUNT;
			check(16'(top + 16'h0004 - e) <= 16'h0008, 1'b1,
				"rate");
			repeat (10) @(posedge CLK);
			check(COUNT, top, "halt");
			DEBUG_HALT <= 1'b0;
		end
		// coherent counter reads at divide by 128
		apb(1'b1, timer_counter_pkg::SC_OFF, 8'h00);
		apb(1'b1, timer_counter_pkg::CNTL_OFF, 8'h00);
		apb(1'b1, timer_counter_pkg::SC_OFF, 8'h0f);
		apb(1'b0, timer_counter_pkg::CNTH_OFF, 8'h00);
		repeat (300) @(posedge CLK);
		apb(1'b0, timer_counter_pkg::CNTL_OFF, 8'h00);
		check(rd, 32'h0, "held");
		apb(1'b0, timer_counter_pkg::CNTL_OFF, 8'h00);
		check(rd, 32'h2, "fresh");
		// same byte again stays held; a control write then releases
		apb(1'b0, timer_counter_pkg::CNTL_OFF, 8'h00);
		check(rd, 32'h2, "same");
		apb(1'b1, timer_counter_pkg::SC_OFF, 8'h0f);
		repeat (100) @(posedge CLK);
		apb(1'b0, timer_counter_pkg::CNTL_OFF, 8'h00);
		check(rd, 32'h3, "restart");
		end_of_test();
	end
endmodule // timer_counter_core_tb
